// ==== verilog/ipec_top.sv ====
// Per-line pending and enable state for 32 external interrupt inputs.
// Assumes a simple register port (sel, write, address, data) on the processor
// clock, exception entry/return strobes from the exception logic, and
// asynchronous interrupt pins that are synchronised here.
`include "ipec_map.svh"
module ipec_top
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] irq_lines,
  input wire logic [31:0] exception_entry_event,
  input wire logic [31:0] exception_return_event,
  input wire logic clear_all_active_request,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire ipec_pkg::ipec_word_t reg_wdata,
  output ipec_pkg::ipec_word_t reg_rdata_ff,
  output logic reg_rvalid_ff,
  output ipec_pkg::ipec_word_t line_pending_state_ff,
  output ipec_pkg::ipec_word_t enable_state_ff,
  output ipec_pkg::ipec_word_t activatable_ff
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Active-high lines from sources
  ipec_pkg::ipec_word_t sync1_ff;
  ipec_pkg::ipec_word_t sync2_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sync1_ff <= `IPEC_RESET_WORD;
    else
      sync1_ff <= irq_lines;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sync2_ff <= `IPEC_RESET_WORD;
    else
      sync2_ff <= sync1_ff;
  end

  // ----------------------------------------
  // Edge history
  // ----------------------------------------
  // Last synchronised level
  ipec_pkg::ipec_word_t prev_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prev_ff <= `IPEC_RESET_WORD;
    else
      prev_ff <= sync2_ff;
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic wr;
  logic hit_es;
  logic hit_ec;
  logic hit_ps;
  logic hit_pc;
  logic hit_pr;
  logic [2:0] prio_idx;

  assign wr = reg_sel && reg_write;
  assign hit_es = (reg_addr == `IPEC_ADDR_ENABLE_SET);
  assign hit_ec = (reg_addr == `IPEC_ADDR_ENABLE_CLEAR);
  assign hit_ps = (reg_addr == `IPEC_ADDR_PENDING_SET);
  assign hit_pc = (reg_addr == `IPEC_ADDR_PENDING_CLEAR);
  assign hit_pr = ((reg_addr & `IPEC_PRIO_BANK_MASK) == `IPEC_ADDR_PRIO_BASE);

  // ----------------------------------------
  // Priority index
  // ----------------------------------------
  // Word within the bank
  assign prio_idx = reg_addr[`IPEC_PRIO_IDX_MSB:`IPEC_PRIO_IDX_LSB];

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  ipec_pkg::ipec_word_t enable_set_bits;
  ipec_pkg::ipec_word_t enable_clear_bits;
  ipec_pkg::ipec_word_t pending_set_bits;
  ipec_pkg::ipec_word_t pending_clear_bits;

  assign enable_set_bits = (wr && hit_es) ? reg_wdata : `IPEC_RESET_WORD;
  assign enable_clear_bits = (wr && hit_ec) ? reg_wdata : `IPEC_RESET_WORD;
  assign pending_set_bits = (wr && hit_ps) ? reg_wdata : `IPEC_RESET_WORD;
  assign pending_clear_bits = (wr && hit_pc) ? reg_wdata : `IPEC_RESET_WORD;

  // ----------------------------------------
  // Per-line pending and enable
  // ----------------------------------------
  ipec_pkg::ipec_word_t nxt_pending;
  ipec_pkg::ipec_word_t nxt_enable;
  ipec_pkg::ipec_word_t nxt_active;

  genvar g;
  generate
    for (g = 0; g < `IPEC_NUM_LINES; g++)
    begin : g_line
      logic edge_seen;
      logic sample_hi;
      logic sample_lo;
      logic assertion;
      logic deassertion;
      logic set_pend;
      logic clr_pend;
      logic pend_hold;
      logic en_on;
      logic en_off;

      assign edge_seen = sync2_ff[g] && !prev_ff[g];
      assign sample_hi = clear_all_active_request || exception_return_event[g];
      assign sample_lo = pending_clear_bits[g];
      assign assertion = edge_seen || (sync2_ff[g] && sample_hi);
      assign deassertion = !sync2_ff[g] && sample_lo;

      assign clr_pend = exception_entry_event[g] || deassertion;
      assign set_pend = assertion || pending_set_bits[g];
      assign pend_hold = line_pending_state_ff[g] && !clr_pend;
      assign nxt_pending[g] = set_pend || pend_hold;

      assign en_on = enable_set_bits[g];
      assign en_off = enable_clear_bits[g];
      assign nxt_enable[g] = en_on || (enable_state_ff[g] && !en_off);

      assign nxt_active[g] = nxt_pending[g] && nxt_enable[g];
    end
  endgenerate

  // ----------------------------------------
  // Pending state
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      line_pending_state_ff <= `IPEC_RESET_WORD;
    else
      line_pending_state_ff <= nxt_pending;
  end

  // ----------------------------------------
  // Enable state
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      enable_state_ff <= `IPEC_RESET_WORD;
    else
      enable_state_ff <= nxt_enable;
  end

  // ----------------------------------------
  // Activation view
  // ----------------------------------------
  // Offered only when enabled
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      activatable_ff <= `IPEC_RESET_WORD;
    else
      activatable_ff <= nxt_active;
  end

  // ----------------------------------------
  // Priority bank
  // ----------------------------------------
  ipec_pkg::ipec_word_t prio_rdata;
  logic prio_wr;

  assign prio_wr = wr && hit_pr;

  ipec_prio_mem ipec_prio_mem_inst
  (
    .clock(clock),
    .nrst(nrst),
    .wr_en(prio_wr),
    .idx(prio_idx),
    .wdata(reg_wdata),
    .rdata_ff(prio_rdata)
  );

  // ----------------------------------------
  // Read select
  // ----------------------------------------
  ipec_pkg::ipec_word_t rd_word;

  always_comb
  begin
    rd_word = `IPEC_RESET_WORD;
    if (hit_es || hit_ec)
      rd_word = enable_state_ff;
    else if (hit_ps || hit_pc)
      rd_word = line_pending_state_ff;
  end

  // ----------------------------------------
  // Read capture
  // ----------------------------------------
  logic rd_req;
  logic rd_pr_ff;
  logic rd_pend_ff;
  ipec_pkg::ipec_word_t rd_word_ff;

  assign rd_req = reg_sel && !reg_write;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rd_pend_ff <= 1'h0;
    else
      rd_pend_ff <= rd_req;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rd_pr_ff <= 1'h0;
    else
      rd_pr_ff <= rd_req && hit_pr;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rd_word_ff <= `IPEC_RESET_WORD;
    else
      rd_word_ff <= rd_word;
  end

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reg_rvalid_ff <= 1'h0;
    else
      reg_rvalid_ff <= rd_pend_ff;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reg_rdata_ff <= `IPEC_RESET_WORD;
    else
      reg_rdata_ff <= rd_pr_ff ? prio_rdata : rd_word_ff;
  end
endmodule : ipec_top

// ==== verilog/ipec_map.svh ====
// Register offsets, field positions and reset values of the pending/enable unit.
// Assumes a 32-bit byte-addressed register port with word-aligned registers on the private peripheral bus.
`ifndef IPEC_MAP_SVH
`define IPEC_MAP_SVH
`define IPEC_ADDR_ENABLE_SET 32'hE000E100
`define IPEC_ADDR_ENABLE_CLEAR 32'hE000E180
`define IPEC_ADDR_PENDING_SET 32'hE000E200
`define IPEC_ADDR_PENDING_CLEAR 32'hE000E280
`define IPEC_ADDR_PRIO_BASE 32'hE000E400
`define IPEC_ADDR_PRIO_LAST 32'hE000E41C
`define IPEC_PRIO_IDX_LSB 2
`define IPEC_PRIO_IDX_MSB 4
`define IPEC_PRIO_BANK_MASK 32'hFFFFFFE0
`define IPEC_PRIO_FIELD_MASK 32'hC0C0C0C0
`define IPEC_RESET_WORD 32'h00000000
`define IPEC_NUM_LINES 32
`define IPEC_NUM_PRIO 8
`endif

// ==== verilog/ipec_pkg.sv ====
// Types shared by the pending/enable unit.
// Assumes ipec_map.svh is compiled alongside.
package ipec_pkg;
  typedef logic [31:0] ipec_word_t;
  typedef logic [1:0] ipec_prio_t;
endpackage : ipec_pkg

// ==== verilog/ipec_prio_mem.sv ====
// Priority register bank: eight words, only the two-bit fields stored.
// Assumes the caller decodes the bank window; read data are registered.
`include "ipec_map.svh"
module ipec_prio_mem
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [2:0] idx,
  input wire ipec_pkg::ipec_word_t wdata,
  output ipec_pkg::ipec_word_t rdata_ff
);
  ipec_pkg::ipec_word_t mem_ff [`IPEC_NUM_PRIO];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `IPEC_NUM_PRIO; g++)
    begin : g_word
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
          mem_ff[g] <= `IPEC_RESET_WORD;
        else if (wr_en && (idx == 3'(g)))
          mem_ff[g] <= wdata & `IPEC_PRIO_FIELD_MASK;
      end
    end
  endgenerate

  // ----------------------------------------
  // Registered read
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_ff <= `IPEC_RESET_WORD;
    else
      rdata_ff <= mem_ff[idx];
  end
endmodule : ipec_prio_mem

// ==== test/ipec_top_asserts.sv ====
// Port checker for the pending/enable unit.
// Assumes it is bound to ipec_top, one clock, reset low.
module ipec_top_asserts
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] irq_lines,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rvalid_ff,
  input wire logic [31:0] line_pending_state_ff,
  input wire logic [31:0] enable_state_ff,
  input wire logic [31:0] activatable_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire wr = reg_sel && reg_write;
  wire rd = reg_sel && !reg_write;
  wire es = wr && reg_addr == 32'hE000E100;
  wire ec = wr && reg_addr == 32'hE000E180;
  wire ps = wr && reg_addr == 32'hE000E200;
  wire pc = wr && reg_addr == 32'hE000E280 && reg_wdata[0];
  property p_act; activatable_ff == (line_pending_state_ff & enable_state_ff); endproperty
  a_act: assert property (p_act) else $error("bad activatable");
  property p_rd; rd |-> ##2 reg_rvalid_ff; endproperty
  a_rd: assert property (p_rd) else $error("late read");
  property p_rv; reg_rvalid_ff |-> $past(rd, 2); endproperty
  a_rv: assert property (p_rv) else $error("stray read");
  property p_es; es |=> enable_state_ff == ($past(enable_state_ff) | $past(reg_wdata)); endproperty
  a_es: assert property (p_es) else $error("bad set");
  property p_ec; ec |=> enable_state_ff == ($past(enable_state_ff) & ~$past(reg_wdata)); endproperty
  a_ec: assert property (p_ec) else $error("bad clear");
  property p_eh; !es && !ec |=> $stable(enable_state_ff); endproperty
  a_eh: assert property (p_eh) else $error("enable moved");
  property p_ps; ps |=> (line_pending_state_ff & $past(reg_wdata)) == $past(reg_wdata); endproperty
  a_ps: assert property (p_ps) else $error("not pending");
  property p_pc; pc && !irq_lines[0] && !$past(irq_lines[0]) && !$past(irq_lines[0], 2)
    |=> !line_pending_state_ff[0]; endproperty
  a_pc: assert property (p_pc) else $error("still pending");
endmodule : ipec_top_asserts
bind ipec_top ipec_top_asserts ipec_top_asserts_inst (.*);

// ==== test/ipec_src_model.sv ====
// Interrupt source model: level lines and stretched pulses.
// Assumes requests change just after the rising edge.
module ipec_src_model
(
  input wire logic clock,
  input wire logic [31:0] lvl,
  input wire logic [31:0] pls,
  output logic [31:0] irq_lines
);
  logic [31:0] hold_ff;
  always_ff @(posedge clock) hold_ff <= pls;
  assign irq_lines = lvl | pls | hold_ff;
endmodule : ipec_src_model

// ==== test/test_irq_pending_enable_ctrl.sv ====
// Bench for the pending/enable unit: registers, lines, events.
// Assumes the source model and the checker are compiled first.
`define CHK(a, b) num_checks++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t mismatch got %h exp %h", $time, a, b); end
module test_irq_pending_enable_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = '0, nrst = '0, reg_sel = '0, reg_write = '0, reg_rvalid_ff;
  logic clear_all_active_request = '0;
  logic [31:0] reg_addr = '0, reg_wdata = '0, exception_entry_event = '0, lvl = '0, pls = '0;
  logic [31:0] exception_return_event = '0, x = 32'h1D, irq_lines, reg_rdata_ff, v, m, e, en;
  logic [31:0] line_pending_state_ff, enable_state_ff, activatable_ff, q[$];
  int fails = 0, num_checks = 0;
  ipec_top ipec_top_inst (.*);
  ipec_src_model ipec_src_model_inst (.*);
  initial forever #5 clock = ~clock;
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    if (!w) q.push_back(d);
    {reg_sel, reg_write, reg_addr, reg_wdata} = {1'h1, w, 20'hE000E, a, d};
    tick(1);
  endtask : bus
  task automatic ev(logic [31:0] i, logic [31:0] o, logic c);
    reg_sel = '0;
    {exception_entry_event, exception_return_event, clear_all_active_request} = {i, o, c};
    tick(1);
    {exception_entry_event, exception_return_event, clear_all_active_request} = '0;
    tick(1);
  endtask : ev
  task automatic conclude();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  always @(negedge clock)
    if (reg_rvalid_ff === 1'h1)
    begin
      e = q.pop_front();
      `CHK(reg_rdata_ff, e)
    end
  initial
  begin
    #20000;
    fails++;
    conclude();
  end
  initial
  begin
    tick(6);
    nrst = '1;
    for (int i = 0; i < 8; i++)
      bus(0, 12'h100 + 12'(i * 128), '0);
    $display("reset test done");
    v = rnd();
    m = rnd();
    bus(1, 12'h100, v);
    bus(0, 12'h180, v);
    bus(1, 12'h180, m);
    bus(0, 12'h100, v & ~m);
    en = v & ~m;
    bus(1, 12'h200, v);
    bus(0, 12'h280, v);
    bus(1, 12'h280, m);
    bus(0, 12'h200, v & ~m);
    bus(1, 12'h280, '1);
    $display("register test done");
    ev(0, 0, 0);
    pls = v;
    lvl = 32'h1;
    tick(1);
    pls = '0;
    tick(5);
    v[0] = 1'h1;
    bus(0, 12'h200, v);
    bus(1, 12'h280, 32'h1);
    bus(0, 12'h200, v);
    ev(1, 0, 0);
    bus(0, 12'h200, v - 1);
    ev(0, 1, 0);
    bus(0, 12'h200, v);
    ev(1, 0, 1);
    bus(0, 12'h200, v);
    $display("line test done");
    for (int i = 0; i < 9; i++)
      bus(1, 12'h400 + 12'(i * 4), v + i);
    for (int i = 0; i < 9; i++)
      bus(0, 12'h400 + 12'(i * 4), i < 8 ? (v + i) & 32'hC0C0C0C0 : '0);
    $display("priority test done");
    ev(0, 0, 0);
    tick(3);
    `CHK(enable_state_ff, en)
    `CHK(line_pending_state_ff, v)
    `CHK(activatable_ff, v & en)
    `CHK(q.size(), 0)
    conclude();
  end
endmodule : test_irq_pending_enable_ctrl
